//--- rtl/ast_top.sv
// Asynchronous serial transceiver with APB register access and pin overrides.
// Assumes pclk at 50 MHz, inputs synchronous to pclk, a 32-bit APB master.
//
// Contract
// - Character written after stop bit left is loaded into shifter at once.
// - Character written during a frame waits until the stop bit is out.
// - Each load into the shifter sets the buffer-empty flag, unless a data write lands in the same cycle.
// - Load puts start at bit 0, stop at 9 or 10, ninth bit at 9.
// - Bit tick after load drives start, data LSB first, then stop.
// - With nothing pending, buffer-empty stays set until the next data write.
// - Done flag sets after stop held one bit time with nothing written.
// - Transmitter on forces the transmit pin to output over its direction bit.
// - Receiver samples at sixteen per bit; one low idle sample starts a bit.
// - Samples 8, 9, 10 of start; two or more high means noise, rehunt.
// - Each data bit is the majority of its samples 8, 9 and 10.
// - Stop accepted on majority high; otherwise bad stop flag is set.
// - Every finished character with no unread one pending goes to the receive register, done flag set.
// - One data address: writes reach transmit side, reads return receive side.
// - In nine-bit mode the received ninth bit is copied on transfer.
// - Unread character pending drops the new one; overrun shows after read.
// - Receiver on forces receive pin to input; port bit still drives pull-up.
// - Reading the receive register clears the receive done flag.
// - Transmit done clears on vector acknowledge or a written one.
// - Double rate divides by eight instead of sixteen.
// - Receiver off sets no receive flag from the line; a data read still clears done and shows a held overrun.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ast_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_vector_ack,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_n,
  output logic rx_pullup_en,
  output logic txd_o,
  output logic txd_oe_n
);
  import ast_pkg::*;

  typedef struct packed {
    ast_rx_st_t rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_vote;
    logic [8:0] rx_sh;
    logic [3:0] rx_bit;
    logic [7:0] rx_data;
    logic rx_ninth_bit;
    logic rx_done_flag;
    logic bad_stop_flag;
    logic ovr;
    logic ovr_pend;
    logic [7:0] tx_data;
    logic tx_pend;
    logic tx_done_flag;
    logic double_rate_select;
    logic receiver_on;
    logic transmitter_on;
    logic nine_bit_select;
    logic tx_ninth_bit;
    logic [3:0] pin;
    logic [DIV_W-1:0] baud;
    logic [31:0] prdata;
  } ast_top_t;

  localparam ast_top_t ST_RST = '{
    rx_st: RX_IDLE, rx_cnt: 4'h0, rx_vote: 3'h0, rx_sh: 9'h000, rx_bit: 4'h0,
    rx_data: 8'h00, rx_ninth_bit: RX9_RST, rx_done_flag: 1'b0, bad_stop_flag: 1'b0,
    ovr: 1'b0, ovr_pend: 1'b0, tx_data: 8'h00, tx_pend: 1'b0, tx_done_flag: 1'b0,
    double_rate_select: 1'b0, receiver_on: 1'b0, transmitter_on: 1'b0,
    nine_bit_select: 1'b0, tx_ninth_bit: 1'b0, pin: 4'h0, baud: BAUD_RST,
    prdata: 32'h0000_0000};

  ast_top_t s_ff;
  ast_top_t nxt_s;

  logic samp_tick;
  logic bit_tick;
  logic tx_take;
  logic tx_done_pulse;
  logic tx_line;
  logic tx_busy;
  logic wr_acc;
  logic rd_acc;
  logic rd_data;
  logic mapped;
  logic [3:0] vote_lo;
  logic [3:0] vote_hi;
  logic [3:0] last;
  logic [3:0] nbits;
  logic [2:0] votes;
  logic maj;
  logic fin;
  logic [31:0] rv;

  // ==================================================
  // Ticks and transmitter
  ast_baud #(.DW(DIV_W)) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(s_ff.baud),
    .double_rate_select(s_ff.double_rate_select),
    .samp_tick(samp_tick),
    .bit_tick(bit_tick)
  );

  ast_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .bit_tick(bit_tick),
    .enable(s_ff.transmitter_on),
    .pend(s_ff.tx_pend),
    .data(s_ff.tx_data),
    .ninth_bit(s_ff.tx_ninth_bit),
    .nine_bit_select(s_ff.nine_bit_select),
    .take(tx_take),
    .done(tx_done_pulse),
    .line(tx_line),
    .busy(tx_busy)
  );

  // ==================================================
  // Bus decode
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign rd_data = rd_acc & (paddr == ADDR_DATA);
  assign mapped = (paddr == ADDR_DATA) | (paddr == ADDR_STAT) | (paddr == ADDR_CTRL) |
                  (paddr == ADDR_BAUD) | (paddr == ADDR_PIN);
  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s_ff.prdata;

  // ==================================================
  // Receiver sampling positions
  always_comb begin
    vote_lo = s_ff.double_rate_select ? VOTE_LO_D : VOTE_LO_N;
    vote_hi = s_ff.double_rate_select ? VOTE_HI_D : VOTE_HI_N;
    last = s_ff.double_rate_select ? LAST_D : LAST_N;
    nbits = s_ff.nine_bit_select ? BITS_9 : BITS_8;
    votes = {s_ff.rx_vote[1:0], rxd_i};
    maj = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
  end

  // ==================================================
  // Read value mux
  always_comb begin
    rv = 32'h0000_0000;
    case (paddr)
      ADDR_DATA: begin
        rv[7:0] = s_ff.rx_data;
      end
      ADDR_STAT: begin
        rv[ST_RXDONE] = s_ff.rx_done_flag;
        rv[ST_TXDONE] = s_ff.tx_done_flag;
        rv[ST_TXEMPTY] = ~s_ff.tx_pend;
        rv[ST_BADSTOP] = s_ff.bad_stop_flag;
        rv[ST_OVR] = s_ff.ovr;
        rv[ST_DBL] = s_ff.double_rate_select;
      end
      ADDR_CTRL: begin
        rv[CT_RXON] = s_ff.receiver_on;
        rv[CT_TXON] = s_ff.transmitter_on;
        rv[CT_NINE] = s_ff.nine_bit_select;
        rv[CT_RX9] = s_ff.rx_ninth_bit;
      end
      ADDR_BAUD: begin
        rv[DIV_W-1:0] = s_ff.baud;
      end
      ADDR_PIN: begin
        rv[3:0] = s_ff.pin;
      end
      default: begin
        rv = 32'h0000_0000;
      end
    endcase
  end

  // ==================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    fin = 1'b0;
    if (psel && !penable) begin
      nxt_s.prdata = rv;
    end

    // Receiver engine
    if (!s_ff.receiver_on) begin
      nxt_s.rx_st = RX_IDLE;
    end else if (samp_tick) begin
      case (s_ff.rx_st)
        RX_IDLE: begin
          if (!rxd_i) begin
            nxt_s.rx_st = RX_START;
            // First low sample is sample 1, so the next tick sees index 1
            nxt_s.rx_cnt = 4'h1;
          end
        end
        RX_START, RX_DATA, RX_STOP: begin
          nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
          if (s_ff.rx_cnt >= vote_lo && s_ff.rx_cnt <= vote_hi) begin
            nxt_s.rx_vote = votes;
          end
          if (s_ff.rx_cnt == vote_hi) begin
            if (s_ff.rx_st == RX_START && maj) begin
              nxt_s.rx_st = RX_IDLE;
            end else if (s_ff.rx_st == RX_DATA) begin
              nxt_s.rx_sh = {maj, s_ff.rx_sh[8:1]};
              nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
            end else if (s_ff.rx_st == RX_STOP) begin
              fin = 1'b1;
              nxt_s.rx_st = RX_IDLE;
            end
          end else if (s_ff.rx_cnt == last) begin
            nxt_s.rx_cnt = 4'h0;
            if (s_ff.rx_st == RX_START) begin
              nxt_s.rx_st = RX_DATA;
              nxt_s.rx_bit = 4'h0;
            end else if (s_ff.rx_bit == nbits) begin
              nxt_s.rx_st = RX_STOP;
            end
          end
        end
        default: begin
          nxt_s.rx_st = RX_IDLE;
        end
      endcase
    end

    // Data read empties the receive side; held overrun now shows
    if (rd_data) begin
      nxt_s.rx_done_flag = 1'b0;
      if (s_ff.ovr_pend) begin
        nxt_s.ovr = 1'b1;
        nxt_s.ovr_pend = 1'b0;
      end
    end
    if (fin) begin
      // Relies on one data read per character
      if (s_ff.rx_done_flag && !rd_data) begin
        nxt_s.ovr_pend = 1'b1;
      end else begin
        nxt_s.rx_data = s_ff.nine_bit_select ? s_ff.rx_sh[7:0] : s_ff.rx_sh[8:1];
        nxt_s.rx_done_flag = 1'b1;
        nxt_s.bad_stop_flag = ~maj;
        nxt_s.ovr = rd_data & s_ff.ovr_pend;
        nxt_s.ovr_pend = 1'b0;
        if (s_ff.nine_bit_select) begin
          nxt_s.rx_ninth_bit = s_ff.rx_sh[8];
        end
      end
    end

    // Transmit side; a write in the cycle of a load wins
    if (tx_take) begin
      nxt_s.tx_pend = 1'b0;
    end
    if (tx_vector_ack) begin
      nxt_s.tx_done_flag = 1'b0;
    end
    if (wr_acc) begin
      case (paddr)
        ADDR_DATA: begin
          nxt_s.tx_data = pwdata[7:0];
          nxt_s.tx_pend = 1'b1;
        end
        ADDR_STAT: begin
          if (pwdata[ST_TXDONE]) begin
            nxt_s.tx_done_flag = 1'b0;
          end
          nxt_s.double_rate_select = pwdata[ST_DBL];
        end
        ADDR_CTRL: begin
          nxt_s.receiver_on = pwdata[CT_RXON];
          nxt_s.transmitter_on = pwdata[CT_TXON];
          nxt_s.nine_bit_select = pwdata[CT_NINE];
          nxt_s.tx_ninth_bit = pwdata[CT_TX9];
        end
        ADDR_BAUD: begin
          nxt_s.baud = pwdata[DIV_W-1:0];
        end
        ADDR_PIN: begin
          nxt_s.pin = pwdata[3:0];
        end
        default: begin
          nxt_s.pin = s_ff.pin;
        end
      endcase
    end
    // Set beats a clear in the same cycle
    if (tx_done_pulse) begin
      nxt_s.tx_done_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==================================================
  // Pin overrides
  // Pin stays with the transmitter until the frame in flight is out
  assign txd_oe_n = ~(s_ff.transmitter_on | tx_busy | s_ff.pin[PN_TXDIR]);
  assign txd_o = (s_ff.transmitter_on | tx_busy) ? tx_line : s_ff.pin[PN_TXVAL];
  assign rxd_oe_n = s_ff.receiver_on | ~s_ff.pin[PN_RXDIR];
  assign rxd_o = s_ff.pin[PN_PULL];
  assign rx_pullup_en = rxd_oe_n & s_ff.pin[PN_PULL];
endmodule

//--- rtl/ast_pkg.sv
// Package for the asynchronous serial transceiver: register map, bit fields,
// reset values, sampling positions and receiver states.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
package ast_pkg;

  // ==================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0C;
  localparam logic [7:0] ADDR_PIN = 8'h10;

  // ==================================================
  // Status fields
  localparam int ST_RXDONE = 7;
  localparam int ST_TXDONE = 6;
  localparam int ST_TXEMPTY = 5;
  localparam int ST_BADSTOP = 4;
  localparam int ST_OVR = 3;
  localparam int ST_DBL = 1;

  // ==================================================
  // Control fields
  localparam int CT_RXON = 4;
  localparam int CT_TXON = 3;
  localparam int CT_NINE = 2;
  localparam int CT_RX9 = 1;
  localparam int CT_TX9 = 0;

  // ==================================================
  // Pin fields
  localparam int PN_RXDIR = 0;
  localparam int PN_TXDIR = 1;
  localparam int PN_PULL = 2;
  localparam int PN_TXVAL = 3;

  // ==================================================
  // Reset values and widths
  localparam int DIV_W = 12;
  localparam logic [11:0] BAUD_RST = 12'h144;
  localparam logic RX9_RST = 1'b1;

  // ==================================================
  // Sample positions, counted from zero (sample 1 is index 0)
  localparam logic [3:0] VOTE_LO_N = 4'h7;
  localparam logic [3:0] VOTE_HI_N = 4'h9;
  localparam logic [3:0] LAST_N = 4'hF;
  localparam logic [3:0] VOTE_LO_D = 4'h3;
  localparam logic [3:0] VOTE_HI_D = 4'h5;
  localparam logic [3:0] LAST_D = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] FRAME_8 = 4'hA;
  localparam logic [3:0] FRAME_9 = 4'hB;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ast_rx_st_t;

endpackage

//--- rtl/ast_baud.sv
// Bit-rate generator: sample tick every divisor+1 clocks, bit tick every
// sixteen (or eight, double rate) sample ticks.
// Assumes one clock domain; ticks are one-cycle pulses.
`timescale 1ns/1ps
module ast_baud #(
  parameter int DW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DW-1:0] divisor,
  input wire logic double_rate_select,
  output logic samp_tick,
  output logic bit_tick
);
  import ast_pkg::*;

  if (DW < 4 || DW > 16) begin : g_chk
    $error("ast_baud: divisor width out of range");
  end

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic [3:0] phase;
    logic samp;
    logic bitt;
  } ast_baud_t;

  ast_baud_t s_ff;
  ast_baud_t nxt_s;
  logic [3:0] last;

  // ==================================================
  // Divider
  always_comb begin
    nxt_s = s_ff;
    nxt_s.samp = 1'b0;
    nxt_s.bitt = 1'b0;
    last = double_rate_select ? LAST_D : LAST_N;
    if (s_ff.cnt == '0) begin
      nxt_s.cnt = divisor;
      nxt_s.samp = 1'b1;
      if (s_ff.phase >= last) begin
        nxt_s.phase = 4'h0;
        nxt_s.bitt = 1'b1;
      end else begin
        nxt_s.phase = s_ff.phase + 4'h1;
      end
    end else begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign samp_tick = s_ff.samp;
  assign bit_tick = s_ff.bitt;
endmodule

//--- rtl/ast_tx.sv
// Transmit shifter: loads from the data register when idle, shifts start,
// data LSB first, optional ninth bit and stop on bit ticks.
// Assumes bit_tick is a one-cycle pulse from the bit-rate generator.
`timescale 1ns/1ps
module ast_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_tick,
  input wire logic enable,
  input wire logic pend,
  input wire logic [7:0] data,
  input wire logic ninth_bit,
  input wire logic nine_bit_select,
  output logic take,
  output logic done,
  output logic line,
  output logic busy
);
  import ast_pkg::*;

  typedef struct packed {
    logic [10:0] sh;
    logic [3:0] left;
    logic busy;
    logic hold;
    logic line;
    logic done;
  } ast_tx_t;

  ast_tx_t s_ff;
  ast_tx_t nxt_s;

  // ==================================================
  // Shifter
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    take = 1'b0;
    if (!s_ff.busy && pend && enable) begin
      // Never loads while a frame still sits in the shifter
      take = 1'b1;
      if (nine_bit_select) begin
        nxt_s.sh = {1'b1, ninth_bit, data, 1'b0};
        nxt_s.left = FRAME_9;
      end else begin
        nxt_s.sh = {2'b11, data, 1'b0};
        nxt_s.left = FRAME_8;
      end
      nxt_s.busy = 1'b1;
      nxt_s.hold = 1'b0;
    end else if (bit_tick) begin
      if (s_ff.busy) begin
        nxt_s.line = s_ff.sh[0];
        nxt_s.sh = {1'b1, s_ff.sh[10:1]};
        nxt_s.left = s_ff.left - 4'h1;
        if (s_ff.left == 4'h1) begin
          nxt_s.busy = 1'b0;
          nxt_s.hold = 1'b1;
        end
      end else if (s_ff.hold) begin
        nxt_s.hold = 1'b0;
        nxt_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{sh: 11'h7FF, left: 4'h0, busy: 1'b0, hold: 1'b0, line: 1'b1, done: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;
  assign line = s_ff.line;
  assign busy = s_ff.busy | s_ff.hold;
endmodule

//--- bench/ast_top_checker.sv
// Checker for the serial transceiver top: pin steering, bus answers, bit time.
// Assumes it is bound to ast_top and sees only that module's ports.
`timescale 1ns/1ps
module ast_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_vector_ack,
  input wire logic rxd_i,
  input wire logic rxd_o,
  input wire logic rxd_oe_n,
  input wire logic rx_pullup_en,
  input wire logic txd_o,
  input wire logic txd_oe_n
);
  import ast_pkg::*;
  // ====================
  // Shadow registers
  logic [4:0] ctl_ff;
  logic [3:0] pin_ff;
  logic [11:0] baud_ff;
  logic dbl_ff;
  logic prev_ff;
  logic fell_ff;
  int run_ff;
  int blen;
  logic acc;
  logic wr;
  logic mapped;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = paddr inside {ADDR_DATA, ADDR_STAT, ADDR_CTRL, ADDR_BAUD, ADDR_PIN};
  assign blen = (int'(baud_ff) + 1) * (dbl_ff ? 8 : 16);
  // Low-run length of the line; only whole bit times may pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= '0;
      pin_ff <= '0;
      baud_ff <= BAUD_RST;
      dbl_ff <= 1'b0;
      prev_ff <= 1'b0;
      fell_ff <= 1'b0;
      run_ff <= 0;
    end else begin
      if (wr && paddr == ADDR_CTRL) ctl_ff <= pwdata[4:0];
      if (wr && paddr == ADDR_PIN) pin_ff <= pwdata[3:0];
      if (wr && paddr == ADDR_BAUD) baud_ff <= pwdata[11:0];
      if (wr && paddr == ADDR_STAT) dbl_ff <= pwdata[ST_DBL];
      prev_ff <= txd_o;
      run_ff <= (txd_o != prev_ff) ? 1 : run_ff + 1;
      fell_ff <= ctl_ff[CT_TXON] && (fell_ff || (prev_ff && !txd_o));
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_tx_bit_len: assert property (
    ctl_ff[CT_TXON] && fell_ff && txd_o && !prev_ff |-> run_ff % blen == 0)
    else $error("transmit low run not whole bit times");
  a_tx_pin_out: assert property (ctl_ff[CT_TXON] |-> !txd_oe_n)
    else $error("transmit pin not driven");
  a_tx_on_hold: assert property (
    wr && paddr == ADDR_CTRL && pwdata[CT_TXON] |=> !txd_oe_n [*2])
    else $error("transmit pin late after enable");
  a_tx_pin_gpio: assert property (
    !ctl_ff[CT_TXON] && pin_ff[PN_TXDIR] |-> !txd_oe_n)
    else $error("transmit pin ignores direction");
  a_rx_pin_in: assert property (ctl_ff[CT_RXON] |-> rxd_oe_n)
    else $error("receive pin driven while receiving");
  a_rx_pin_gpio: assert property (
    !ctl_ff[CT_RXON] |-> rxd_oe_n == !pin_ff[PN_RXDIR])
    else $error("receive pin ignores direction");
  a_rx_pull_up: assert property (
    ctl_ff[CT_RXON] |-> rx_pullup_en == pin_ff[PN_PULL])
    else $error("pull-up not following port bit");
  a_unmapped_err: assert property (acc |-> pslverr == !mapped)
    else $error("slave error wrong");
  a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

//--- bench/ast_remote_node.sv
// Remote serial node: sends frames to the receive line, decodes the transmit line.
// Assumes the bench sets bit_clks and rx_bits while the line is quiet.
`timescale 1ns/1ps
module ast_remote_node (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out,
  output logic got,
  output logic [9:0] got_data
);
  int bit_clks = 32;
  int rx_bits = 8;
  logic [9:0] sh;
  initial begin
    line_out = 1'b1;
    got = 1'b0;
    got_data = '0;
  end
  // ====================
  // Sender
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    @(posedge pclk);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (bit_clks) @(posedge pclk);
    end
    line_out <= stop;
    repeat (bit_clks) @(posedge pclk);
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge pclk);
  endtask
  task automatic spike(input int n);
    @(posedge pclk);
    line_out <= 1'b0;
    repeat (n) @(posedge pclk);
    line_out <= 1'b1;
  endtask
  // ====================
  // Receiver, mid-bit sampling; stop bit lands above the data
  always begin
    wait (line_in === 1'b1);
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge pclk);
    sh = '0;
    for (int i = 0; i <= rx_bits; i++) begin
      repeat (bit_clks) @(posedge pclk);
      sh[i] = line_in;
    end
    got_data <= sh;
    got <= 1'b1;
    @(posedge pclk);
    got <= 1'b0;
  end
endmodule

//--- bench/test_async_serial_transceiver.sv
// Bench for the serial transceiver: APB driver, remote node, result watcher.
// Assumes the package, design, checker and node model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, g); miscompares++; end end
module test_async_serial_transceiver;
  import ast_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; logic err;} ast_note_t;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, tx_vector_ack, pready, pslverr;
  logic rxd_o, rxd_oe_n, rx_pullup_en, txd_o, txd_oe_n, line_out, got;
  logic [7:0] paddr, d0, d1;
  logic [31:0] pwdata, prdata, seed;
  logic [9:0] got_data;
  ast_note_t note_q[$];
  ast_note_t n;
  logic [9:0] tx_q[$];
  int miscompares = 0;
  int checks_done = 0;
  always #10 pclk = ~pclk;
  ast_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_vector_ack(tx_vector_ack), .rxd_i(rxd_oe_n ? line_out : rxd_o),
    .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n), .rx_pullup_en(rx_pullup_en), .txd_o(txd_o),
    .txd_oe_n(txd_oe_n));
  ast_remote_node node (.pclk(pclk), .line_in(txd_oe_n ? 1'b1 : txd_o),
    .line_out(line_out), .got(got), .got_data(got_data));
  // ====================
  // Bus and wait tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    logic r;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      r = pready;
      q = prdata;
    end while (r !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic err);
    logic [31:0] q;
    note_q.push_back('{e, m, err});
    apb(1'b0, a, 32'h0, q);
  endtask
  task automatic poll();
    logic [31:0] q;
    for (int i = 0; i < 400; i++) begin
      note_q.push_back('{32'h0, 32'h0, 1'b0});
      apb(1'b0, ADDR_STAT, 32'h0, q);
      if (q[ST_RXDONE] === 1'b1) break;
    end
    if (q[ST_RXDONE] !== 1'b1) miscompares++;
  endtask
  task automatic wait_tx(input int extra);
    for (int i = 0; i < 30000 && tx_q.size() != 0; i++) @(posedge pclk);
    if (tx_q.size() != 0) miscompares++;
    repeat (extra) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ====================
  // Watcher: oldest note against each read, oldest queued frame against each decoded frame
  always @(negedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && note_q.size() > 0) begin
      n = note_q.pop_front();
      if (n.m != 0) begin
        `CHK($sformatf("reg %h", paddr), n.e, prdata & n.m)
        `CHK("pslverr", n.err, pslverr)
      end
    end
    if (got === 1'b1) begin
      n.e = tx_q.size() ? 32'(tx_q.pop_front()) : 'x;
      `CHK("frame", n.e[9:0], got_data)
    end
  end
  // Generous span: about fifteen frames plus polling
  initial begin
    #1500000;
    miscompares++;
    give_verdict();
  end
  // ====================
  // Scenarios
  initial begin
    {psel, penable, pwrite, tx_vector_ack, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    seed = 32'hC5A08D3E;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_STAT, 32'h20, 32'hFFFFFFFF, 1'b0);
    rd(ADDR_CTRL, 32'h02, 32'hFFFFFFFF, 1'b0);
    rd(ADDR_BAUD, 32'h144, 32'hFFFFFFFF, 1'b0);
    rd(8'h14, 32'h0, 32'hFFFFFFFF, 1'b1);
    // Port value high so the transmit line idles high before the enable
    wr(ADDR_PIN, 32'hF);
    wr(ADDR_BAUD, 32'h1);
    wr(ADDR_CTRL, 32'h18);
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    tx_q.push_back({2'b01, d0});
    tx_q.push_back({2'b01, d1});
    wr(ADDR_DATA, {24'h0, d0});
    rd(ADDR_STAT, 32'h20, 32'h20, 1'b0);
    wr(ADDR_DATA, {24'h0, d1});
    rd(ADDR_STAT, 32'h0, 32'h20, 1'b0);
    wait_tx(64);
    rd(ADDR_STAT, 32'h60, 32'h60, 1'b0);
    wr(ADDR_STAT, 32'h40);
    rd(ADDR_STAT, 32'h0, 32'h40, 1'b0);
    node.rx_bits = 9;
    wr(ADDR_CTRL, 32'h1D);
    tx_q.push_back({2'b11, d0});
    wr(ADDR_DATA, {24'h0, d0});
    wait_tx(64);
    rd(ADDR_STAT, 32'h40, 32'h40, 1'b0);
    tx_vector_ack <= 1'b1;
    @(posedge pclk);
    tx_vector_ack <= 1'b0;
    rd(ADDR_STAT, 32'h0, 32'h40, 1'b0);
    wr(ADDR_CTRL, 32'h18);
    node.rx_bits = 8;
    for (int i = 0; i < 4; i++) begin
      d0 = 8'($random(seed));
      node.send({1'b0, d0}, 8, i != 3);
      poll();
      rd(ADDR_STAT, (i == 3) ? 32'h90 : 32'h80, 32'h98, 1'b0);
      rd(ADDR_DATA, {24'h0, d0}, 32'hFF, 1'b0);
      rd(ADDR_STAT, 32'h0, 32'h80, 1'b0);
    end
    node.spike(8);
    // Long enough for a wrongly accepted start to finish a whole frame
    repeat (400) @(posedge pclk);
    rd(ADDR_STAT, 32'h0, 32'h80, 1'b0);
    node.send({1'b0, d0}, 8, 1'b1);
    node.send({1'b0, d1}, 8, 1'b1);
    rd(ADDR_STAT, 32'h80, 32'h88, 1'b0);
    rd(ADDR_DATA, {24'h0, d0}, 32'hFF, 1'b0);
    rd(ADDR_STAT, 32'h08, 32'h88, 1'b0);
    wr(ADDR_CTRL, 32'h1C);
    for (int b = 0; b < 2; b++) begin
      node.send({b[0], d1}, 9, 1'b1);
      poll();
      rd(ADDR_CTRL, {30'h0, b[0], 1'b0}, 32'h02, 1'b0);
      rd(ADDR_DATA, {24'h0, d1}, 32'hFF, 1'b0);
      rd(ADDR_STAT, 32'h0, 32'h18, 1'b0);
    end
    // Receive pin as input so the disabled receiver really sees the line
    wr(ADDR_PIN, 32'hE);
    wr(ADDR_CTRL, 32'h08);
    node.send({1'b0, d0}, 8, 1'b0);
    rd(ADDR_STAT, 32'h0, 32'h98, 1'b0);
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_STAT, 32'h02);
    node.bit_clks = 16;
    tx_q.push_back({2'b01, d1});
    wr(ADDR_DATA, {24'h0, d1});
    node.send({1'b0, d0}, 8, 1'b1);
    poll();
    rd(ADDR_DATA, {24'h0, d0}, 32'hFF, 1'b0);
    wait_tx(16);
    give_verdict();
  end
endmodule
bind ast_top ast_top_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_vector_ack(tx_vector_ack), .rxd_i(rxd_i),
  .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n), .rx_pullup_en(rx_pullup_en), .txd_o(txd_o),
  .txd_oe_n(txd_oe_n));
